// ---- inc/rsb_pkg.sv ----
// Purpose: Shared constants of the radio status readback bank
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes:   Byte address of a register is four times its index
package rsb_pkg;

	localparam int unsigned DATA_W      = 32;
	localparam int unsigned IDX_W       = 10;
	localparam int unsigned CLK_NS      = 100;
	// Answer comes one edge after the request is seen
	localparam int unsigned ACK_NS      = 100;
	localparam int unsigned ACK_CYCLES  = (ACK_NS + CLK_NS - 1) / CLK_NS;

	// Register indices
	localparam logic [9:0] IDX_STRENGTH   = 10'h042;
	localparam logic [9:0] IDX_AVG_OFFS   = 10'h043;
	localparam logic [9:0] IDX_INST_OFFS  = 10'h044;
	localparam logic [9:0] IDX_SYNTH_CAL  = 10'h045;
	localparam logic [9:0] IDX_VERS_TUNE  = 10'h046;
	localparam logic [9:0] IDX_OSC_CAL    = 10'h047;
	localparam logic [9:0] IDX_CONV_SAMP  = 10'h048;
	localparam logic [9:0] IDX_FILT_I     = 10'h049;
	localparam logic [9:0] IDX_FILT_Q     = 10'h04a;
	localparam logic [9:0] IDX_GAIN_OFFS  = 10'h04b;
	localparam logic [9:0] IDX_CTRL       = 10'h04c;

	// Field positions (low bit of each field)
	localparam int unsigned STRENGTH_LO   = 0;
	localparam int unsigned CAL_DAC_LO    = 4;
	localparam int unsigned CHP_LO        = 0;
	localparam int unsigned VERSION_LO    = 5;
	localparam int unsigned TUNE_LO       = 0;
	localparam int unsigned FCOMP_BIT     = 7;
	localparam int unsigned CUR_CMP_BIT   = 6;
	localparam int unsigned OSC_CAL_LO    = 0;
	localparam int unsigned MIX_LO        = 6;
	localparam int unsigned CONV_I_LO     = 3;
	localparam int unsigned CONV_Q_LO     = 0;
	localparam int unsigned GAIN_OFFS_LO  = 0;
	localparam int unsigned CTRL_TEST_BIT = 0;

	// Reset values
	localparam logic       CTRL_TEST_RST  = 1'b1;
	localparam logic [7:0] WORD_ZERO      = 8'h00;

endpackage : rsb_pkg

// ---- src/rsb_sync.sv ----
// Purpose: Two-flop synchroniser for levels from outside the clock
// Assumes: Inputs are slow levels; no bus coherence across bits
// Notes:   First stage is read only by the second stage
module rsb_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage1 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end

endmodule // rsb_sync

// ---- src/rsb_bank.sv ----
// Purpose: Status and readback bank on classic Wishbone; only the control word is writable
// Assumes: Readback sources run on clk_i except the two comparators
// Notes:   Comparator bits are synchronised, so they read two cycles old
//          Unmapped addresses answer with err_o instead of ack_o
//
// The Wishbone register port was decided locally.

// How it works
// - Unused strength and gain-offset bits read zero
// - Strength is 7-bit, 1.5 dB per count
// - Averaged deviation word is signed decision level
// - Average offset equals rate times value over 16
// - Instantaneous offset word is signed 8-bit
// - Instant offset equals rate times value over 8
// - Word 45h: calibration converter, charge pump level
// - Word 46h upper three bits: silicon version
// - Word 46h low bits: applied tuning array
// - Word 47h bit 7: frequency comparator, synchronised
// - Word 47h bit 6: reference above core current
// - Word 47h low bits: applied calibration current
// - Word 48h: mixer, in-phase, quadrature converter samples
// - Words 49h, 4Ah: upper filter I and Q
// - Word 4Bh low bits: configured minus applied gain
module rsb_bank #(
	parameter int unsigned ADR_W     = 12,
	parameter int unsigned FILTER_W  = 12,
	// Arbitrary neutral version code
	parameter logic [2:0]  SILICON_VERSION = 3'h3
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone classic slave
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [ADR_W-1:0]    adr_i,
	input  wire logic [3:0]          sel_i,
	input  wire logic [31:0]         dat_i,
	output logic      [31:0]         dat_o,
	output logic                     ack_o,
	output logic                     err_o,
	// Receive path readback, on clk_i
	input  wire logic [6:0]          rx_strength_level_i,
	input  wire logic [7:0]          avg_offset_value_i,
	input  wire logic [7:0]          instant_offset_value_i,
	// Synthesizer readback, on clk_i
	input  wire logic [3:0]          cal_dac_level_i,
	input  wire logic [3:0]          charge_pump_level_i,
	input  wire logic [4:0]          osc_tuning_array_i,
	input  wire logic [5:0]          osc_cal_level_i,
	// Analog comparators, asynchronous
	input  wire logic                freq_compare_i,
	input  wire logic                osc_current_compare_i,
	// Converter and filter samples, on clk_i
	input  wire logic [1:0]          mixer_sample_i,
	input  wire logic [2:0]          conv_inphase_i,
	input  wire logic [2:0]          conv_quad_i,
	input  wire logic [FILTER_W-1:0] filter_inphase_i,
	input  wire logic [FILTER_W-1:0] filter_quad_i,
	input  wire logic [4:0]          gain_offset_i,
	// Control state
	output logic                     test_enable_o
);

	logic [9:0] idx;
	logic       req;
	logic       test_enable;
	logic [1:0] cmp_sync;
	logic [7:0] next_rdata;

	assign idx           = adr_i[11:2];
	assign req           = cyc_i & stb_i & ~ack_o & ~err_o;
	assign test_enable_o = test_enable;

	function automatic logic is_mapped(input logic [9:0] i);
		is_mapped = (i >= rsb_pkg::IDX_STRENGTH) &&
			(i <= rsb_pkg::IDX_CTRL);
	endfunction

	function automatic logic is_test(input logic [9:0] i);
		is_test = (i >= rsb_pkg::IDX_SYNTH_CAL) &&
			(i <= rsb_pkg::IDX_GAIN_OFFS);
	endfunction

	// Comparators come straight from analog, so they are synchronised
	rsb_sync #(
		.WIDTH (2)
	) u_cmp_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({freq_compare_i, osc_current_compare_i}),
		.sync_o  (cmp_sync)
	);

	// Read word selection; values are sampled live at the request
	always_comb begin
		next_rdata = rsb_pkg::WORD_ZERO;
		unique case (idx)
			rsb_pkg::IDX_STRENGTH: begin
				next_rdata[6:0] = rx_strength_level_i;
			end
			rsb_pkg::IDX_AVG_OFFS: begin
				next_rdata = avg_offset_value_i;
			end
			rsb_pkg::IDX_INST_OFFS: begin
				next_rdata = instant_offset_value_i;
			end
			rsb_pkg::IDX_SYNTH_CAL: begin
				next_rdata[7:4] = cal_dac_level_i;
				next_rdata[3:0] = charge_pump_level_i;
			end
			rsb_pkg::IDX_VERS_TUNE: begin
				next_rdata[7:5] = SILICON_VERSION;
				next_rdata[4:0] = osc_tuning_array_i;
			end
			rsb_pkg::IDX_OSC_CAL: begin
				next_rdata[7]   = cmp_sync[1];
				next_rdata[6]   = cmp_sync[0];
				next_rdata[5:0] = osc_cal_level_i;
			end
			rsb_pkg::IDX_CONV_SAMP: begin
				next_rdata[7:6] = mixer_sample_i;
				next_rdata[5:3] = conv_inphase_i;
				next_rdata[2:0] = conv_quad_i;
			end
			rsb_pkg::IDX_FILT_I: begin
				next_rdata = filter_inphase_i[FILTER_W-1 -: 8];
			end
			rsb_pkg::IDX_FILT_Q: begin
				next_rdata = filter_quad_i[FILTER_W-1 -: 8];
			end
			rsb_pkg::IDX_GAIN_OFFS: begin
				next_rdata[4:0] = gain_offset_i;
			end
			rsb_pkg::IDX_CTRL: begin
				next_rdata[rsb_pkg::CTRL_TEST_BIT] = test_enable;
			end
			default: begin
				next_rdata = rsb_pkg::WORD_ZERO;
			end
		endcase
		// Test words can be hidden so normal code never leans on them
		if (is_test(idx) && !test_enable) begin
			next_rdata = rsb_pkg::WORD_ZERO;
		end
	end

	// Bus answer: one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end else begin
			ack_o <= req & is_mapped(idx);
			err_o <= req & ~is_mapped(idx);
		end
	end

	// Read data, no side effect on any source
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= '0;
		end else if (req && !we_i) begin
			dat_o <= {24'h000000, next_rdata};
		end
	end

	// Only the control word stores a write; readback words ignore it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			test_enable <= rsb_pkg::CTRL_TEST_RST;
		end else if (req && we_i && sel_i[0] &&
			idx == rsb_pkg::IDX_CTRL) begin
			test_enable <= dat_i[rsb_pkg::CTRL_TEST_BIT];
		end
	end

	// Checks

	a_strength_read: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && idx == rsb_pkg::IDX_STRENGTH)
		|=> ack_o && dat_o[6:0] == $past(rx_strength_level_i)
	) else $error("strength readback mismatch");

	a_unused_zero: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && (idx == rsb_pkg::IDX_STRENGTH ||
			idx == rsb_pkg::IDX_GAIN_OFFS))
		|=> dat_o[31:7] == '0 && (dat_o[6:5] == 2'b00 ||
			$past(idx) == rsb_pkg::IDX_STRENGTH)
	) else $error("unused bits not zero");

	a_avg_offset: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && idx == rsb_pkg::IDX_AVG_OFFS)
		|=> ack_o && $signed(dat_o[7:0]) ==
			$signed($past(avg_offset_value_i))
	) else $error("averaged offset mismatch");

	a_inst_offset: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && idx == rsb_pkg::IDX_INST_OFFS)
		|=> ack_o && dat_o[7:0] == $past(instant_offset_value_i)
	) else $error("instant offset mismatch");

	a_synth_cal: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && test_enable && idx == rsb_pkg::IDX_SYNTH_CAL)
		|=> dat_o[7:4] == $past(cal_dac_level_i) &&
			dat_o[3:0] == $past(charge_pump_level_i)
	) else $error("calibration word mismatch");

	a_version_tune: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && test_enable && idx == rsb_pkg::IDX_VERS_TUNE)
		|=> dat_o[7:5] == SILICON_VERSION &&
			dat_o[4:0] == $past(osc_tuning_array_i)
	) else $error("version word mismatch");

	a_freq_comp: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && test_enable && idx == rsb_pkg::IDX_OSC_CAL)
		|=> dat_o[7] == $past(freq_compare_i, 3) &&
			dat_o[6] == $past(osc_current_compare_i, 3)
	) else $error("comparator bits stale or wrong");

	a_osc_cal: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && test_enable && idx == rsb_pkg::IDX_OSC_CAL)
		|=> dat_o[5:0] == $past(osc_cal_level_i)
	) else $error("calibration current mismatch");

	a_conv_sample: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && test_enable && idx == rsb_pkg::IDX_CONV_SAMP)
		|=> dat_o[7:0] == $past({mixer_sample_i, conv_inphase_i,
			conv_quad_i})
	) else $error("converter sample mismatch");

	a_filter_upper: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && test_enable && idx == rsb_pkg::IDX_FILT_Q)
		|=> dat_o[7:0] == $past(filter_quad_i[FILTER_W-1 -: 8])
	) else $error("filter upper bits mismatch");

	a_gain_offset: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && test_enable && idx == rsb_pkg::IDX_GAIN_OFFS)
		|=> dat_o[4:0] == $past(gain_offset_i)
	) else $error("gain offset mismatch");

	a_write_ignored: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && we_i && idx != rsb_pkg::IDX_CTRL)
		|=> $stable(test_enable) && $stable(dat_o) && ack_o == is_mapped(
			$past(idx))
	) else $error("write to readback word had effect");

	a_ack_single: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o ##1 (!ack_o || $past(req))
	) else $error("ack held longer than one cycle");

	a_tune_array: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && test_enable && idx == rsb_pkg::IDX_VERS_TUNE)
		|=> ack_o && dat_o[4:0] == $past(osc_tuning_array_i)
	) else $error("tuning array readback mismatch");

	a_cur_compare: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && test_enable && idx == rsb_pkg::IDX_OSC_CAL)
		|=> ack_o && dat_o[6] == $past(osc_current_compare_i, 3)
	) else $error("current comparator bit mismatch");

	// Comparator path is two flops deep, no more and no less
	a_cmp_sync_depth: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && !$past(rst_i, 2) |->
		cmp_sync == $past({freq_compare_i, osc_current_compare_i}, 2)
	) else $error("comparator synchroniser depth wrong");

	a_filter_inphase: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && test_enable && idx == rsb_pkg::IDX_FILT_I)
		|=> dat_o[7:0] == $past(filter_inphase_i[FILTER_W-1 -: 8])
	) else $error("filter in-phase upper bits mismatch");

	// Hidden test words must not leak while access is switched off
	a_test_hidden: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && !test_enable && is_test(idx))
		|=> ack_o && dat_o == '0
	) else $error("test word visible while hidden");

	a_ctrl_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && we_i && sel_i[0] && idx == rsb_pkg::IDX_CTRL)
		|=> ack_o && test_enable == $past(dat_i[rsb_pkg::CTRL_TEST_BIT])
	) else $error("control write not stored");

	a_ctrl_read: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && idx == rsb_pkg::IDX_CTRL)
		|=> dat_o == {31'h0, $past(test_enable)}
	) else $error("control readback mismatch");

	// Reset leaves the bus idle and the test words visible
	a_reset_state: assert property (
		@(posedge clk_i)
		rst_i |=> !ack_o && !err_o && dat_o == '0 &&
			test_enable == rsb_pkg::CTRL_TEST_RST
	) else $error("state after reset wrong");

	a_err_unmapped: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && !is_mapped(idx))
		|=> err_o && !ack_o && (dat_o == '0 || $past(we_i))
	) else $error("unmapped access not refused");

	a_answer_once: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(req && is_mapped(idx)) |=> ack_o && !err_o
	) else $error("mapped access not acknowledged");

	a_no_spurious: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!req |=> !ack_o && !err_o
	) else $error("answer without request");

	// Only a taken read may move the read data
	a_read_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!(req && !we_i) |=> $stable(dat_o)
	) else $error("read data moved without a read");

	a_upper_zero: assert property (
		@(posedge clk_i) disable iff (rst_i)
		dat_o[31:8] == '0
	) else $error("read data upper bits not zero");

	a_answer_excl: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!(ack_o && err_o)
	) else $error("ack and err together");

endmodule // rsb_bank

// ---- bench/rsb_bank_test.sv ----
// Purpose: Self-checking bench for the status readback bank
// Assumes: Classic Wishbone master, inputs held steady around reads
// Notes:   Comparator inputs settle 4 cycles before reads (sync delay)
module rsb_bank_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [11:0] adr_i = 12'h000;
	logic [3:0]  sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic        ack_o, err_o, test_enable_o;
	logic [6:0]  rx_strength_level_i = '0;
	logic [7:0]  avg_offset_value_i = '0, instant_offset_value_i = '0;
	logic [3:0]  cal_dac_level_i = '0, charge_pump_level_i = '0;
	logic [4:0]  osc_tuning_array_i = '0, gain_offset_i = '0;
	logic [5:0]  osc_cal_level_i = '0;
	logic        freq_compare_i = 1'b0, osc_current_compare_i = 1'b0;
	logic [1:0]  mixer_sample_i = '0;
	logic [2:0]  conv_inphase_i = '0, conv_quad_i = '0;
	logic [11:0] filter_inphase_i = '0, filter_quad_i = '0;
	int          bad_count = 0;
	int          tests_run = 0;

	rsb_bank rsb_bank_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .err_o, .rx_strength_level_i,
		.avg_offset_value_i, .instant_offset_value_i, .cal_dac_level_i,
		.charge_pump_level_i, .osc_tuning_array_i, .osc_cal_level_i,
		.freq_compare_i, .osc_current_compare_i, .mixer_sample_i,
		.conv_inphase_i, .conv_quad_i, .filter_inphase_i, .filter_quad_i,
		.gain_offset_i, .test_enable_o);

	always #50 clk_i = ~clk_i;

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, exp, input string m);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, exp, input string m);
		check_word({31'h0, got}, {31'h0, exp}, m);
	endtask

	// Waits for ack or err; no fixed latency is assumed
	task automatic wb_cycle(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
		rd = dat_o;
		er = err_o;
		check_bit(n < 20, 1'b1, "bus answer");
		cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
	endtask

	// Spreads one seed over every readback source
	task automatic drive(input logic [7:0] s);
		@(posedge clk_i);
		rx_strength_level_i <= s[6:0];
		avg_offset_value_i <= s; instant_offset_value_i <= ~s;
		cal_dac_level_i <= s[3:0]; charge_pump_level_i <= s[7:4];
		osc_tuning_array_i <= s[4:0]; osc_cal_level_i <= s[5:0];
		freq_compare_i <= s[7]; osc_current_compare_i <= s[0];
		mixer_sample_i <= s[1:0]; conv_inphase_i <= s[4:2];
		conv_quad_i <= s[7:5]; gain_offset_i <= s[6:2];
		filter_inphase_i <= {s, 4'h5}; filter_quad_i <= {~s, 4'ha};
		repeat (4) @(posedge clk_i);
	endtask

	function automatic logic [31:0] exp_word(input logic [9:0] i,
		input logic [7:0] s, input logic en);
		logic [7:0] v;
		case (i)
			10'h042: v = {1'b0, s[6:0]};
			10'h043: v = s;
			10'h044: v = ~s;
			10'h045: v = {s[3:0], s[7:4]};
			10'h046: v = {3'h3, s[4:0]};
			10'h047: v = {s[7], s[0], s[5:0]};
			10'h048: v = {s[1:0], s[4:2], s[7:5]};
			10'h049: v = s;
			10'h04a: v = ~s;
			default: v = {3'h0, s[6:2]};
		endcase
		// Test words are gated off while test access is disabled
		if (!en && i > 10'h044)
			v = 8'h00;
		return {24'h0, v};
	endfunction

	task automatic read_bank(input logic [7:0] s, input logic en);
		logic [31:0] rd;
		logic        er;
		for (int i = 'h42; i <= 'h4b; i++) begin
			wb_cycle(1'b0, {i[9:0], 2'b00}, 32'h0, rd, er);
			check_word(rd, exp_word(i[9:0], s, en), "read word");
			check_bit(er, 1'b0, "mapped err");
		end
	endtask

	initial begin
		repeat (5000) @(posedge clk_i);
		bad_count++;
		complete_run();
	end

	initial begin
		logic [31:0] rd;
		logic        er;
		logic [7:0]  seeds [4];
		seeds = '{8'ha5, 8'h5a, 8'hff, 8'h00};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check_bit(test_enable_o, 1'b1, "test enable reset");
		foreach (seeds[k]) begin
			drive(seeds[k]);
			read_bank(seeds[k], 1'b1);
		end
		$display("test live readback done");
		for (int i = 'h42; i <= 'h4b; i++)
			wb_cycle(1'b1, {i[9:0], 2'b00}, 32'hfffffffe, rd, er);
		check_bit(test_enable_o, 1'b1, "write side effect");
		read_bank(8'h00, 1'b1);
		$display("test ignored writes done");
		wb_cycle(1'b0, 12'h104, 32'h0, rd, er);
		check_bit(er, 1'b1, "unmapped read err");
		check_word(rd, 32'h0, "unmapped read data");
		wb_cycle(1'b1, 12'h134, 32'h1, rd, er);
		check_bit(er, 1'b1, "unmapped write err");
		$display("test unmapped done");
		drive(8'h3c);
		wb_cycle(1'b1, 12'h130, 32'h0, rd, er);
		check_bit(test_enable_o, 1'b0, "test enable off");
		read_bank(8'h3c, 1'b0);
		wb_cycle(1'b1, 12'h130, 32'h1, rd, er);
		check_bit(test_enable_o, 1'b1, "test enable on");
		read_bank(8'h3c, 1'b1);
		$display("test enable gating done");
		wb_cycle(1'b1, 12'h130, 32'h0, rd, er);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check_bit(test_enable_o, 1'b1, "test enable after reset");
		check_word(dat_o, 32'h0, "read data after reset");
		read_bank(8'h3c, 1'b1);
		$display("test mid-run reset done");
		complete_run();
	end
endmodule // rsb_bank_test
